//--- shared/scan_seq_pkg.sv
// constants and carrier types of the frequency scan sequencer
package scan_seq_pkg;
    localparam int          WORD_BITS         = 16;
    localparam int          HALF_BITS         = 12;
    localparam int          FREQ_BITS         = 24;
    localparam int          DAC_BITS_DEFAULT  = 10;
    localparam logic [3:0]  ADDR_CONTROL      = 4'h0;
    localparam logic [3:0]  ADDR_STEP_COUNT   = 4'h1;
    localparam logic [3:0]  ADDR_STEP_LO      = 4'h2;
    localparam logic [3:0]  ADDR_STEP_HI      = 4'h3;
    localparam logic [3:0]  ADDR_START_LO     = 4'hc;
    localparam logic [3:0]  ADDR_START_HI     = 4'hd;
    localparam logic [1:0]  ADDR_INTERVAL_TOP = 2'h1;
    localparam int          CTRL_PAIR_BIT     = 11;
    localparam int          CTRL_EXT_BIT      = 5;
    localparam int          INTERVAL_BASE_BIT = 13;
    localparam logic [11:0] CONTROL_RESET     = 12'h000;
    localparam logic [11:0] COUNT_RESET       = 12'h000;
    localparam logic [23:0] FREQ_RESET        = 24'h000000;
    localparam logic [13:0] INTERVAL_RESET    = 14'h0001;
    localparam logic [3:0]  LAST_BIT_INDEX    = 4'hf;

    typedef enum {SCAN_IDLE, SCAN_RUN, SCAN_HOLD} scan_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [11:0] data;
    } serial_word_t;

    typedef struct packed {
        logic [11:0] control;
        logic [11:0] count;
        logic [23:0] step;
        logic [23:0] start;
        logic [13:0] interval;
        logic [11:0] stage;
    } scan_profile_t;
endpackage

//--- src/frequency_scan_sequencer.sv
// frequency scan sequencer: serial word loader, profile registers and scan engine
module frequency_scan_sequencer
    import scan_seq_pkg::*;
#(
    parameter int DAC_BITS = DAC_BITS_DEFAULT
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                serialClk,
    input  wire logic                frameSelectN,
    input  wire logic                serialIn,
    input  wire logic                scanTrigger,
    input  wire logic                haltIn,
    output logic [FREQ_BITS-1:0]     freqWord,
    output logic [DAC_BITS-1:0]      dacCode,
    output logic                     scanActive,
    output logic                     scanDone
);

    if (DAC_BITS < 1 || DAC_BITS > FREQ_BITS) begin : g_bad_width
        $error("dac width must lie between 1 and the phase width");
    end

    localparam logic [DAC_BITS-1:0] DAC_MID = {1'b1, {(DAC_BITS-1){1'b0}}};

    function automatic logic isReserved(input logic [3:0] a);
        isReserved = (a[3:2] == 2'h2) || (a[3:1] == 3'h7);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side, falling serial clock edges

    logic [3:0]   bitCntReg;
    logic [3:0]   bitCntNext;
    logic [14:0]  shiftReg;
    logic [14:0]  shiftNext;
    serial_word_t heldReg;
    serial_word_t heldNext;
    logic         toggleReg;
    logic         toggleNext;

    always_comb begin
        bitCntNext = bitCntReg + 4'h1;
        shiftNext  = {shiftReg[13:0], serialIn};
        heldNext   = heldReg;
        toggleNext = toggleReg;
        if (bitCntReg == LAST_BIT_INDEX) begin
            heldNext   = {shiftReg, serialIn};
            toggleNext = ~toggleReg;
        end
    end

    // frame high clears the count, so a parked clock of either level is harmless
    always_ff @(negedge serialClk or posedge frameSelectN) begin
        if (frameSelectN) begin
            bitCntReg <= 4'h0;
        end else begin
            bitCntReg <= bitCntNext;
        end
    end

    always_ff @(negedge serialClk or posedge rst) begin
        if (rst) begin
            toggleReg <= 1'b0;
        end else if (!frameSelectN) begin
            toggleReg <= toggleNext;
        end
    end

    // data only; qualified by the toggle, so no reset is needed
    always_ff @(negedge serialClk) begin
        shiftReg <= shiftNext;
        heldReg  <= heldNext;
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers: stage 0 feeds stage 1 only, stage 2 is the edge history

    logic [2:0] trigSyncReg;
    logic [2:0] trigSyncNext;
    logic [2:0] haltSyncReg;
    logic [2:0] haltSyncNext;
    logic [2:0] togSyncReg;
    logic [2:0] togSyncNext;
    logic       trigEdge;
    logic       haltEdge;
    logic       newWord;

    always_comb begin
        trigSyncNext = {trigSyncReg[1:0], scanTrigger};
        haltSyncNext = {haltSyncReg[1:0], haltIn};
        togSyncNext  = {togSyncReg[1:0], toggleReg};
        trigEdge     = trigSyncReg[1] & ~trigSyncReg[2];
        haltEdge     = haltSyncReg[1] & ~haltSyncReg[2];
        newWord      = togSyncReg[1] ^ togSyncReg[2];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trigSyncReg <= 3'h0;
            haltSyncReg <= 3'h0;
            togSyncReg  <= 3'h0;
        end else begin
            trigSyncReg <= trigSyncNext;
            haltSyncReg <= haltSyncNext;
            togSyncReg  <= togSyncNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // profile registers

    scan_profile_t profReg;
    scan_profile_t profNext;
    logic [3:0]    wAddr;
    logic [11:0]   wData;
    logic          pairMode;

    // held word is stable for many master clocks after the toggle lands
    always_comb begin
        wAddr    = heldReg.addr;
        wData    = heldReg.data;
        pairMode = profReg.control[CTRL_PAIR_BIT];
        profNext = profReg;
        if (newWord && !isReserved(wAddr)) begin
            unique casez (wAddr)
                ADDR_CONTROL:    profNext.control = wData;
                ADDR_STEP_COUNT: profNext.count = wData;
                ADDR_STEP_LO: begin
                    if (pairMode) begin
                        profNext.stage = wData;
                    end else begin
                        profNext.step[11:0] = wData;
                    end
                end
                ADDR_STEP_HI: begin
                    if (pairMode) begin
                        profNext.step = {wData, profReg.stage};
                    end else begin
                        profNext.step[23:12] = wData;
                    end
                end
                ADDR_START_LO: begin
                    if (pairMode) begin
                        profNext.stage = wData;
                    end else begin
                        profNext.start[11:0] = wData;
                    end
                end
                ADDR_START_HI: begin
                    if (pairMode) begin
                        profNext.start = {wData, profReg.stage};
                    end else begin
                        profNext.start[23:12] = wData;
                    end
                end
                4'b01??: profNext.interval = {wAddr[1:0], wData};
                default: profNext = profReg;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            profReg <= '{CONTROL_RESET, COUNT_RESET, FREQ_RESET, FREQ_RESET,
                         INTERVAL_RESET, COUNT_RESET};
        end else begin
            profReg <= profNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan engine

    scan_state_t          stateReg;
    scan_state_t          stateNext;
    logic [FREQ_BITS-1:0] freqReg;
    logic [FREQ_BITS-1:0] freqNext;
    logic [FREQ_BITS-1:0] phaseReg;
    logic [FREQ_BITS-1:0] phaseNext;
    logic [11:0]          leftReg;
    logic [11:0]          leftNext;
    logic [11:0]          tickCntReg;
    logic [11:0]          tickCntNext;
    logic [DAC_BITS-1:0]  dacReg;
    logic [DAC_BITS-1:0]  dacNext;
    logic                 activeNext;
    logic                 doneNext;
    logic                 ctrlWrite;
    logic                 extMode;
    logic [FREQ_BITS:0]   phaseSum;
    logic                 tick;
    logic                 intervalEnd;
    logic                 advance;
    logic                 startScan;

    always_comb begin
        ctrlWrite   = newWord && (wAddr == ADDR_CONTROL);
        extMode     = profReg.control[CTRL_EXT_BIT];
        phaseSum    = {1'b0, phaseReg} + {1'b0, freqReg};
        // output-cycle base counts accumulator wraps, one per waveform period
        tick        = profReg.interval[INTERVAL_BASE_BIT] ? phaseSum[FREQ_BITS] : 1'b1;
        intervalEnd = tick && ({1'b0, tickCntReg} + 13'h0001 >= {1'b0, profReg.interval[11:0]});
        advance     = (stateReg == SCAN_RUN) && (extMode ? trigEdge : intervalEnd);
        startScan   = trigEdge && !(extMode && stateReg == SCAN_RUN);
        stateNext   = stateReg;
        freqNext    = freqReg;
        leftNext    = leftReg;
        tickCntNext = tickCntReg;
        phaseNext   = (stateReg == SCAN_IDLE) ? phaseReg : phaseSum[FREQ_BITS-1:0];
        if (haltEdge || ctrlWrite) begin
            stateNext = SCAN_IDLE;
            phaseNext = FREQ_RESET;
        end else if (startScan) begin
            stateNext   = SCAN_RUN;
            freqNext    = profReg.start;
            leftNext    = profReg.count;
            tickCntNext = 12'h000;
            phaseNext   = FREQ_RESET;
        end else if (advance) begin
            tickCntNext = 12'h000;
            if (leftReg == 12'h000) begin
                stateNext = SCAN_HOLD;
            end else begin
                freqNext = freqReg + profReg.step;
                leftNext = leftReg - 12'h001;
            end
        end else if (stateReg == SCAN_RUN && tick && !extMode) begin
            tickCntNext = tickCntReg + 12'h001;
        end
        // idle holds midscale until a trigger starts a scan
        dacNext    = (stateNext == SCAN_IDLE) ? DAC_MID
                   : phaseNext[FREQ_BITS-1 -: DAC_BITS];
        activeNext = (stateNext == SCAN_RUN);
        doneNext   = (stateNext == SCAN_HOLD);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateReg   <= SCAN_IDLE;
            freqReg    <= FREQ_RESET;
            phaseReg   <= FREQ_RESET;
            leftReg    <= COUNT_RESET;
            tickCntReg <= 12'h000;
            dacReg     <= DAC_MID;
            scanActive <= 1'b0;
            scanDone   <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            freqReg    <= freqNext;
            phaseReg   <= phaseNext;
            leftReg    <= leftNext;
            tickCntReg <= tickCntNext;
            dacReg     <= dacNext;
            scanActive <= activeNext;
            scanDone   <= doneNext;
        end
    end

    assign freqWord = freqReg;
    assign dacCode  = dacReg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence resetCause;
        haltEdge || ctrlWrite;
    endsequence

    sequence quietRun;
        !haltEdge && !ctrlWrite && !startScan;
    endsequence

    halt_to_mid_a: assert property (haltEdge |=> stateReg == SCAN_IDLE && dacCode == DAC_MID)
        else $error("halt edge did not force midscale");
    ctrl_write_reset_a: assert property (ctrlWrite |=> stateReg == SCAN_IDLE && phaseReg == '0)
        else $error("control write did not reset scan");
    idle_stays_mid_a: assert property (resetCause ##1 (!trigEdge)[*2] |-> dacCode == DAC_MID)
        else $error("output left midscale without trigger");
    start_loads_a: assert property (startScan && !haltEdge && !ctrlWrite
        |=> freqWord == $past(profReg.start) && scanActive)
        else $error("trigger did not load start word");
    step_adds_a: assert property ((advance && leftReg != 12'h000) and quietRun
        |=> freqWord == $past(freqReg) + $past(profReg.step))
        else $error("step did not add step word");
    phase_keeps_a: assert property ((stateReg != SCAN_IDLE) and quietRun
        |=> phaseReg == $past(phaseSum[FREQ_BITS-1:0]))
        else $error("phase jumped on a step");
    hold_final_a: assert property ((stateReg == SCAN_HOLD) and quietRun
        |=> stateReg == SCAN_HOLD && $stable(freqReg))
        else $error("final frequency not held");
    last_interval_a: assert property ((advance && leftReg == 12'h000) and quietRun
        |=> scanDone && !scanActive)
        else $error("scan did not end after last interval");
    reserved_drop_a: assert property (newWord && isReserved(wAddr) |=> $stable(profReg))
        else $error("reserved word changed a register");
    auto_no_trig_a: assert property ((stateReg == SCAN_RUN && !extMode && intervalEnd) and quietRun
        |=> tickCntReg == 12'h000)
        else $error("auto interval did not restart");

endmodule

//--- sim/serial_host_model.sv
// serial host model: frames 16-bit words onto the three-wire link
module serial_host_model (
    output logic serialClk,
    output logic frameSelectN,
    output logic serialIn
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam time HALF = 32ns;

    // a time-zero frame edge may be missed, so raise it once after start to clear the count
    initial begin
        serialClk = 1'b0;
        frameSelectN = 1'b0;
        serialIn = 1'b1;
        #HALF;
        frameSelectN = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame, words back to back; link clock parks at the given level between frames
    task automatic send(input logic [15:0] words[$], input logic park);
        logic [15:0] w;
        serialClk = park;
        #HALF;
        frameSelectN = 1'b0;
        #HALF;
        foreach (words[k]) begin
            w = words[k];
            for (int i = 15; i >= 0; i--) begin
                serialClk = 1'b1;
                serialIn = w[i];
                #HALF;
                serialClk = 1'b0;
                #HALF;
            end
        end
        frameSelectN = 1'b1;
        serialIn = ~serialIn;
        serialClk = park;
        #HALF;
    endtask
endmodule

//--- sim/frequency_scan_sequencer_test.sv
// self-checking bench of the frequency scan sequencer
module frequency_scan_sequencer_test
    import scan_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        rst;
    logic        serialClk;
    logic        frameSelectN;
    logic        serialIn;
    logic        scanTrigger;
    logic        haltIn;
    logic [23:0] freqWord;
    logic [9:0]  dacCode;
    logic        scanActive;
    logic        scanDone;
    logic [23:0] expQ[$];
    logic [23:0] startW;
    logic [23:0] stepW;
    logic [23:0] prevFreq;
    logic        prevActive;
    logic        prevDone;
    int          gap = 0;
    int          expGap = 0;
    int          fails = 0;
    int          comparisons = 0;

    frequency_scan_sequencer dut (
        .sys_clk(sys_clk), .rst(rst), .serialClk(serialClk), .frameSelectN(frameSelectN),
        .serialIn(serialIn), .scanTrigger(scanTrigger), .haltIn(haltIn), .freqWord(freqWord),
        .dacCode(dacCode), .scanActive(scanActive), .scanDone(scanDone)
    );
    serial_host_model host (
        .serialClk(serialClk), .frameSelectN(frameSelectN), .serialIn(serialIn)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic report(input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (e !== g) begin
            fails++;
            $display("FAIL at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic check_freq(input logic [23:0] e, input logic [23:0] g);
        report(e, g);
    endtask

    task automatic check_flags(input logic [1:0] e);
        report({22'h0, e}, {22'h0, scanActive, scanDone});
    endtask

    task automatic check_dac(input logic [9:0] e);
        report({14'h0, e}, {14'h0, dacCode});
    endtask

    task automatic check_count(input logic [15:0] e, input logic [15:0] g);
        report({8'h0, e}, {8'h0, g});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // trigger or halt pulse, long enough for the two-stage sync
    task automatic pulse(input logic useHalt);
        if (useHalt) haltIn = 1'b1;
        else scanTrigger = 1'b1;
        cyc(4);
        scanTrigger = 1'b0;
        haltIn = 1'b0;
        cyc(4);
    endtask

    task automatic load_profile(input logic [11:0] ctrl, input logic [11:0] cnt,
                                input logic [13:0] ivl, input logic park);
        logic [15:0] w[$];
        w = '{{ADDR_CONTROL, ctrl}, {ADDR_STEP_COUNT, cnt}, {ADDR_STEP_LO, stepW[11:0]},
              {ADDR_STEP_HI, stepW[23:12]}, {ADDR_START_LO, startW[11:0]},
              {ADDR_START_HI, startW[23:12]}, {ADDR_INTERVAL_TOP, ivl}};
        host.send(w, park);
        cyc(10);
    endtask

    task automatic queue_scan(input int n);
        for (int k = 0; k < n; k++) expQ.push_back(startW + 24'(k) * stepW);
    endtask

    task automatic wait_done();
        for (int i = 0; i < 3000 && scanDone !== 1'b1; i++) cyc(1);
        if (scanDone !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watcher: every new scan word is matched against the oldest note
    always @(negedge sys_clk) begin
        gap = gap + 1;
        if ((scanActive === 1'b1 || scanDone === 1'b1) && (freqWord !== prevFreq
            || (scanActive === 1'b1 && prevActive !== 1'b1))) begin
            if (expQ.size() == 0) check_freq(24'hffffff ^ freqWord, freqWord);
            else check_freq(expQ.pop_front(), freqWord);
            if (expGap != 0 && prevActive === 1'b1) check_count(16'(expGap), 16'(gap));
            gap = 0;
        end else if (scanDone === 1'b1 && prevDone !== 1'b1 && expGap != 0) begin
            check_count(16'(expGap), 16'(gap));
        end
        prevFreq = freqWord;
        prevActive = scanActive;
        prevDone = scanDone;
    end

    initial begin
        #500us;
        fails++;
        close_out();
    end

    initial begin
        rst = 1'b0;
        scanTrigger = 1'b0;
        haltIn = 1'b0;
        void'($urandom(57729));
        startW = {12'($urandom), 12'($urandom)};
        stepW = {12'($urandom), 12'($urandom)} | 24'h000001;
        // a real rising reset edge, since the link toggle clears on it
        cyc(1);
        rst = 1'b1;
        cyc(20);
        rst = 1'b0;
        cyc(2);
        check_dac(10'h200);
        check_flags(2'b00);
        // auto mode, sys clock base, 200 cycles a step; reserved words sent mid-scan
        load_profile(12'h000, 12'h003, 14'h00c8, 1'b0);
        expGap = 200;
        queue_scan(4);
        pulse(1'b0);
        fork
            host.send('{16'h8abc, 16'he123, 16'hf0ff}, 1'b0);
        join_none
        wait_done();
        cyc(60);
        check_freq(startW + 24'(3) * stepW, freqWord);
        check_flags(2'b01);
        host.send('{16'h0000}, 1'b1);
        cyc(8);
        check_dac(10'h200);
        check_flags(2'b00);
        cyc(30);
        check_dac(10'h200);
        // external stepping: each further trigger edge is one step
        expGap = 0;
        load_profile(12'h020, 12'h002, 14'h00c8, 1'b1);
        queue_scan(3);
        for (int k = 0; k < 3; k++) pulse(1'b0);
        check_flags(2'b10);
        pulse(1'b0);
        check_flags(2'b01);
        // halt mid-scan drops to midscale
        load_profile(12'h000, 12'h003, 14'h00c8, 1'b0);
        expGap = 200;
        queue_scan(1);
        pulse(1'b0);
        cyc(100);
        pulse(1'b1);
        check_dac(10'h200);
        check_flags(2'b00);
        // paired halves, single interval scan
        startW = {12'($urandom), 12'($urandom)};
        load_profile(12'h800, 12'h000, 14'h0010, 1'b1);
        expGap = 16;
        queue_scan(1);
        pulse(1'b0);
        wait_done();
        // output-cycle base: quarter-scale increment wraps every 4 clocks, 5 wraps per step
        startW = 24'h400000;
        load_profile(12'h000, 12'h000, 14'h2005, 1'b0);
        expGap = 20;
        queue_scan(1);
        pulse(1'b0);
        wait_done();
        cyc(5);
        check_count(16'h0000, 16'(expQ.size()));
        close_out();
    end
endmodule
